// ---- verilog/priority_arbiter.sv ----
// interrupt priority arbiter: detection, priority registers and ranking
module priority_arbiter
    import prio_arbiter_pkg::*;
(
    input  wire logic            clock,
    input  wire logic            rst_n,
    input  wire logic [9:0]      adr_i,
    input  wire logic [31:0]     dat_i,
    output logic      [31:0]     dat_o,
    input  wire logic            we_i,
    input  wire logic [3:0]      sel_i,
    input  wire logic            cyc_i,
    input  wire logic            stb_i,
    output logic                 ack_o,
    input  wire logic            nmiPin,
    input  wire logic [7:0]      extPin_n,
    input  wire periph_req_type  periphReq,
    output core_req_type         coreReq,
    input  wire core_accept_type coreAccept,
    output core_mask_type        coreMask
);

    // ******************************************************************
    // state
    // ******************************************************************
    typedef struct packed {
        logic [7:0][15:0] prio;        // priority_level_regs
        logic             nmiEdgeSel;  // nonmask_edge_select
        logic [7:0]       senseSel;    // ext_pin_sense_select, index = pin
        logic [7:0]       edgeFlag;    // held edge requests, index = pin
        logic [7:0]       readSeen;    // flag read as one since last write
        logic             nmiPend;     // held nonmaskable request
        logic             armed;       // previous pin samples are valid
        logic             nmiPrev;     // last nonmaskable pin sample
        logic [7:0]       extPrev;     // last external pin samples
        logic             ack;         // bus acknowledge
        logic [31:0]      rdData;      // bus read data
        core_req_type     req;         // offer to the core
        core_mask_type    mask;        // mask load to the core
    } state_type;

    state_type st_r;                   // registered state
    state_type st_nxt;                 // next state

    // ******************************************************************
    // helpers
    // ******************************************************************
    // level of a source picked out of its priority nibble
    function automatic logic [3:0] srcLevel(input logic [7:0][15:0] prio,
                                            input int idx);
        logic [4:0] f;
        f = SRC_FIELD[idx];
        return prio[f[4:2]][f[1:0]*4 +: 4];
    endfunction : srcLevel

    // flags as software sees them, bit 7 holds pin 0
    function automatic logic [7:0] statusView(input logic [7:0] sense,
                                              input logic [7:0] flags,
                                              input logic [7:0] pins_n);
        logic [7:0] v;
        v = '0;
        for (int i = 0; i < NUM_EXT; i++) begin
            // level mode shows the live pin, edge mode the held flag
            v[7-i] = sense[i] ? flags[i] : ~pins_n[i];
        end
        return v;
    endfunction : statusView

    // ******************************************************************
    // combinational next state
    // ******************************************************************
    logic [NUM_SRC-1:0] pend;          // pending per source
    logic [4:0]         bestLvl;       // winning level so far
    logic [7:0]         bestVec;       // winning vector so far
    logic               bestHit;       // any unmasked request
    logic               busReq;        // new bus request this cycle
    logic               nmiEdge;       // selected nonmaskable edge seen
    logic [7:0]         fallEdge;      // falling edges per pin
    logic [7:0]         stView;        // current status register view
    logic [15:0]        wrData;        // low half of the write data
    logic [15:0]        wrMaskd;       // write data merged by byte lanes
    logic [7:0]         regIdx;        // register index of the access
    logic [7:0]         acceptHit;     // pins whose vector was accepted

    always_comb begin
        st_nxt    = st_r;
        pend      = '0;
        bestLvl   = '0;
        bestVec   = '0;
        bestHit   = 1'b0;
        acceptHit = '0;
        regIdx    = adr_i[9:2];
        wrData    = dat_i[15:0];
        busReq    = cyc_i && stb_i && !st_r.ack;
        stView    = statusView(st_r.senseSel, st_r.edgeFlag, extPin_n);

        // pin samples, edges only count once a previous sample exists
        st_nxt.armed   = 1'b1;
        st_nxt.nmiPrev = nmiPin;
        st_nxt.extPrev = extPin_n;
        nmiEdge = st_r.armed && (st_r.nmiEdgeSel ? (!st_r.nmiPrev && nmiPin)
                                                 : (st_r.nmiPrev && !nmiPin));
        fallEdge = st_r.armed ? (st_r.extPrev & ~extPin_n) : 8'h00;

        // byte lane merge of the write data onto the addressed register
        wrMaskd = 16'h0000;
        unique case (regIdx)
            IDX_DETECT_CTRL: wrMaskd = {7'h00, st_r.nmiEdgeSel, 8'h00};
            IDX_EXT_STATUS:  wrMaskd = 16'hFFFF; // untouched lanes keep flags
            default: begin
                if (regIdx >= IDX_PRIO_FIRST && regIdx <= IDX_PRIO_EIGHTH) begin
                    wrMaskd = st_r.prio[3'((regIdx - IDX_PRIO_FIRST) >> 1)];
                end
            end
        endcase
        for (int b = 0; b < 2; b++) begin
            if (sel_i[b]) begin
                wrMaskd[b*8 +: 8] = wrData[b*8 +: 8];
            end
        end

        // ****** acceptance by the core ******
        st_nxt.mask.load = 1'b0;
        if (coreAccept.accept) begin
            st_nxt.mask.load = 1'b1;
            if (coreAccept.vector == NMI_VECTOR) begin
                st_nxt.nmiPend    = 1'b0;
                st_nxt.mask.level = NMI_MASK_SET;
            end else begin
                st_nxt.mask.level = LEVEL_MASKED;
                for (int s = 0; s < NUM_SRC; s++) begin
                    if (coreAccept.vector == SRC_VECTOR[s]) begin
                        st_nxt.mask.level = srcLevel(st_r.prio, s);
                        if (s < NUM_EXT) begin
                            acceptHit[s] = 1'b1;
                        end
                    end
                end
            end
        end

        // ****** register bus ******
        st_nxt.ack = busReq;
        if (busReq && !we_i) begin
            st_nxt.rdData = '0; // unmapped and reserved bits read zero
            unique case (regIdx)
                IDX_DETECT_CTRL: begin
                    st_nxt.rdData[NMI_LEVEL_BIT] = nmiPin;
                    st_nxt.rdData[NMI_EDGE_BIT]  = st_r.nmiEdgeSel;
                    for (int i = 0; i < NUM_EXT; i++) begin
                        st_nxt.rdData[7-i] = st_r.senseSel[i];
                    end
                end
                IDX_EXT_STATUS: begin
                    st_nxt.rdData[7:0] = stView;
                    if (sel_i[0]) begin
                        // remember which edge flags were seen as one
                        for (int i = 0; i < NUM_EXT; i++) begin
                            if (st_r.senseSel[i] && stView[7-i]) begin
                                st_nxt.readSeen[i] = 1'b1;
                            end
                        end
                    end
                end
                default: begin
                    if (regIdx >= IDX_PRIO_FIRST && regIdx <= IDX_PRIO_EIGHTH) begin
                        st_nxt.rdData[15:0] = st_r.prio[3'((regIdx - IDX_PRIO_FIRST) >> 1)];
                    end
                end
            endcase
        end
        if (busReq && we_i) begin
            unique case (regIdx)
                IDX_DETECT_CTRL: begin
                    st_nxt.nmiEdgeSel = wrMaskd[NMI_EDGE_BIT];
                    for (int i = 0; i < NUM_EXT; i++) begin
                        if (sel_i[0]) begin
                            st_nxt.senseSel[i] = wrData[7-i];
                        end
                    end
                end
                IDX_EXT_STATUS: begin
                    for (int i = 0; i < NUM_EXT; i++) begin
                        // a zero clears only a flag read as one before
                        if (sel_i[0] && !wrData[7-i] && st_r.readSeen[i]) begin
                            st_nxt.edgeFlag[i] = 1'b0;
                        end
                    end
                    st_nxt.readSeen = '0;
                end
                default: begin
                    if (regIdx >= IDX_PRIO_FIRST && regIdx <= IDX_PRIO_EIGHTH) begin
                        // reserved nibbles are never stored
                        st_nxt.prio[3'((regIdx - IDX_PRIO_FIRST) >> 1)] = wrMaskd &
                            PRIO_WMASK[3'((regIdx - IDX_PRIO_FIRST) >> 1)];
                    end
                end
            endcase
        end

        // ****** external pin detection ******
        for (int i = 0; i < NUM_EXT; i++) begin
            if (acceptHit[i]) begin
                st_nxt.edgeFlag[i] = 1'b0;
            end
            if (!st_r.senseSel[i]) begin
                // level mode keeps no held state
                st_nxt.edgeFlag[i] = 1'b0;
                st_nxt.readSeen[i] = 1'b0;
            end else if (fallEdge[i]) begin
                st_nxt.edgeFlag[i] = 1'b1; // new edge beats any clear
            end
        end

        // nonmaskable request, a new edge beats the acceptance clear
        if (nmiEdge) begin
            st_nxt.nmiPend = 1'b1;
        end

        // ****** ranking ******
        for (int i = 0; i < NUM_EXT; i++) begin
            pend[i] = st_r.senseSel[i] ? st_r.edgeFlag[i] : !extPin_n[i];
        end
        pend[NUM_SRC-1:NUM_EXT] = periphReq;
        // ascending vector walk, strict compare keeps the earlier on a tie
        for (int s = 0; s < NUM_SRC; s++) begin
            if (pend[s] && srcLevel(st_r.prio, s) != LEVEL_MASKED &&
                {1'b0, srcLevel(st_r.prio, s)} > bestLvl) begin
                bestLvl = {1'b0, srcLevel(st_r.prio, s)};
                bestVec = SRC_VECTOR[s];
                bestHit = 1'b1;
            end
        end
        // nonmaskable wins over everything and ignores any mask
        if (st_r.nmiPend) begin
            bestLvl = NMI_LEVEL;
            bestVec = NMI_VECTOR;
            bestHit = 1'b1;
        end
        st_nxt.req.valid     = bestHit;
        st_nxt.req.level     = bestLvl;
        st_nxt.req.vector    = bestVec;
        st_nxt.req.tableAddr = {bestVec, 2'b00};
        // the request just accepted is not offered again next cycle
        if (coreAccept.accept && bestVec == coreAccept.vector) begin
            st_nxt.req.valid = 1'b0;
        end
    end

    // ******************************************************************
    // registers, synchronous reset
    // ******************************************************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_r      <= '0; // all priorities zero, sources masked
        end else begin
            st_r      <= st_nxt;
        end
    end

    // ******************************************************************
    // outputs straight from flops
    // ******************************************************************
    assign ack_o    = st_r.ack;
    assign dat_o    = st_r.rdData;
    assign coreReq  = st_r.req;
    assign coreMask = st_r.mask;

endmodule : priority_arbiter

// ---- verilog/prio_arbiter_pkg.sv ----
// constants, tables and carrier types of the interrupt priority arbiter
package prio_arbiter_pkg;

    // ******************************************************************
    // register indices (byte address is four times the index)
    // ******************************************************************
    localparam logic [7:0] IDX_PRIO_FIRST   = 8'h48; // pins 0-3
    localparam logic [7:0] IDX_PRIO_SECOND  = 8'h4A; // pins 4-7
    localparam logic [7:0] IDX_PRIO_THIRD   = 8'h4C; // all reserved
    localparam logic [7:0] IDX_PRIO_FOURTH  = 8'h4E; // timer units 0 and 1
    localparam logic [7:0] IDX_PRIO_FIFTH   = 8'h50; // timer unit 2
    localparam logic [7:0] IDX_PRIO_SIXTH   = 8'h52; // serial port
    localparam logic [7:0] IDX_PRIO_SEVENTH = 8'h54; // converter, compare timers
    localparam logic [7:0] IDX_PRIO_EIGHTH  = 8'h56; // byte timers
    localparam logic [7:0] IDX_DETECT_CTRL  = 8'h58; // detect_control_reg
    localparam logic [7:0] IDX_EXT_STATUS   = 8'h5A; // ext_request_status_reg

    // ******************************************************************
    // field positions and reset values
    // ******************************************************************
    localparam int          NMI_LEVEL_BIT   = 15;      // pin level, read only
    localparam int          NMI_EDGE_BIT    = 8;       // nonmask_edge_select
    localparam logic [15:0] PRIO_RESET      = 16'h0000;
    localparam logic [15:0] STATUS_RESET    = 16'h0000;
    // writable bits of each priority register, reserved nibbles read zero
    localparam logic [7:0][15:0] PRIO_WMASK = {
        16'hF000, 16'hF0FF, 16'h000F, 16'hFF00,
        16'hFFFF, 16'h0000, 16'hFFFF, 16'hFFFF};

    // ******************************************************************
    // sources, vectors and levels
    // ******************************************************************
    localparam int          NUM_EXT      = 8;
    localparam int          NUM_PERIPH   = 20;
    localparam int          NUM_SRC      = 28;      // ordered by vector number
    localparam logic [7:0]  NMI_VECTOR   = 8'h0B;   // 11
    localparam logic [4:0]  NMI_LEVEL    = 5'h10;   // 16
    localparam logic [3:0]  NMI_MASK_SET = 4'hF;    // mask level after nmi
    localparam logic [3:0]  LEVEL_MASKED = 4'h0;
    // vector number per source, index 0 is pin 0
    localparam logic [NUM_SRC-1:0][7:0] SRC_VECTOR = {
        8'h99, 8'h98, 8'h94, 8'h90, 8'h8A, 8'h87, 8'h86, 8'h85, 8'h84,
        8'h6C, 8'h69, 8'h68, 8'h64, 8'h61, 8'h60,
        8'h5C, 8'h5B, 8'h5A, 8'h59, 8'h58,
        8'h47, 8'h46, 8'h45, 8'h44, 8'h43, 8'h42, 8'h41, 8'h40};
    // {register 0..7, nibble 0..3} feeding each source's level
    localparam logic [NUM_SRC-1:0][4:0] SRC_FIELD = {
        5'h1F, 5'h1F, 5'h18, 5'h19, 5'h1B, 5'h14, 5'h14, 5'h14, 5'h14,
        5'h12, 5'h13, 5'h13, 5'h0C, 5'h0D, 5'h0D,
        5'h0E, 5'h0F, 5'h0F, 5'h0F, 5'h0F,
        5'h04, 5'h05, 5'h06, 5'h07, 5'h00, 5'h01, 5'h02, 5'h03};

    // ******************************************************************
    // carrier types
    // ******************************************************************
    typedef struct packed {           // on-chip requests, lsb first in rank
        logic byteTimer2Req;
        logic byteTimer1Req;
        logic compareTimer1Req;
        logic compareTimer0Req;
        logic converterDoneReq;
        logic serialTxEndReq;
        logic serialTransmitReq;
        logic serialReceiveReq;
        logic serialErrorReq;
        logic unit2Overflow;
        logic unit2CompareB;
        logic unit2CompareA;
        logic unit1Overflow;
        logic unit1CompareB;
        logic unit1CompareA;
        logic unit0Overflow;
        logic unit0CompareD;
        logic unit0CompareC;
        logic unit0CompareB;
        logic unit0CompareA;
    } periph_req_type;

    typedef struct packed {           // request offered to the core
        logic       valid;
        logic [4:0] level;
        logic [7:0] vector;
        logic [9:0] tableAddr;
    } core_req_type;

    typedef struct packed {           // acceptance reported by the core
        logic       accept;
        logic [7:0] vector;
    } core_accept_type;

    typedef struct packed {           // new core mask level on acceptance
        logic       load;
        logic [3:0] level;
    } core_mask_type;

endpackage : prio_arbiter_pkg

// ---- dv/priority_arbiter_sva.sv ----
// checker on the arbiter's bus and core ports
module priority_arbiter_sva
    import prio_arbiter_pkg::*;
(
    input wire logic            clock,
    input wire logic            rst_n,
    input wire logic            cyc_i,
    input wire logic            stb_i,
    input wire logic            ack_o,
    input wire core_req_type    coreReq,
    input wire core_accept_type coreAccept,
    input wire core_mask_type   coreMask
);
    timeunit 1ns;
    timeprecision 1ns;
    // ******************************
    // sequences and assertions
    // ******************************
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // request still waiting for its answer
    sequence busReq;
        cyc_i && stb_i && !ack_o;
    endsequence
    // core takes the nonmaskable vector
    sequence nmiTaken;
        coreAccept.accept && coreAccept.vector == NMI_VECTOR;
    endsequence
    // core takes the maskable source now offered
    sequence srcTaken;
        coreAccept.accept && coreReq.valid && coreReq.vector == coreAccept.vector
            && coreReq.vector != NMI_VECTOR;
    endsequence
    a_ack_answer: assert property (busReq |=> ack_o)
        else $error("bus request not answered");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_unasked: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without request");
    a_table_addr: assert property (coreReq.valid |->
        coreReq.tableAddr == {coreReq.vector, 2'b00})
        else $error("table address not four times vector");
    a_level_nonzero: assert property (coreReq.valid |-> coreReq.level != 5'h00)
        else $error("masked level offered");
    a_nmi_top: assert property (coreReq.valid |->
        ((coreReq.vector == NMI_VECTOR) == (coreReq.level == NMI_LEVEL)))
        else $error("level 16 not tied to nonmaskable");
    a_vector_known: assert property (coreReq.valid |->
        coreReq.vector inside {8'h0B, [8'h40:8'h47], [8'h58:8'h5C], 8'h60, 8'h61, 8'h64,
        8'h68, 8'h69, 8'h6C, [8'h84:8'h87], 8'h8A, 8'h90, 8'h94, 8'h98, 8'h99})
        else $error("undefined vector offered");
    a_mask_nmi: assert property (nmiTaken |=>
        coreMask.load && coreMask.level == NMI_MASK_SET)
        else $error("mask not 15 after nonmaskable");
    a_mask_level: assert property (srcTaken |=>
        coreMask.load && coreMask.level == $past(coreReq.level[3:0]))
        else $error("mask not source level");
    a_load_cause: assert property (coreMask.load |-> $past(coreAccept.accept))
        else $error("mask load without acceptance");
endmodule : priority_arbiter_sva

bind priority_arbiter priority_arbiter_sva u_sva (.clock(clock), .rst_n(rst_n), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .coreReq(coreReq), .coreAccept(coreAccept), .coreMask(coreMask));

// ---- dv/core_model.sv ----
// behavioural core that takes the offered request, promptly or slowly
module core_model
    import prio_arbiter_pkg::*;
(
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire core_req_type coreReq,
    input  wire logic         acceptEn,
    input  wire logic [3:0]   waitCycles,
    output core_accept_type   coreAccept
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] seen_r; // cycles the request has been offered
    logic [1:0] gap_r;  // settle time, valid drops a cycle after a take
    // one-cycle take; vector garbled outside it so nothing leans on it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            coreAccept <= '0;
            seen_r <= '0;
            gap_r <= '0;
        end else begin
            coreAccept.accept <= 1'b0;
            coreAccept.vector <= ~coreAccept.vector;
            if (gap_r != 2'h0) begin
                gap_r <= gap_r - 2'h1;
            end else if (acceptEn && coreReq.valid && seen_r >= waitCycles) begin
                coreAccept.accept <= 1'b1;
                coreAccept.vector <= coreReq.vector;
                seen_r <= '0;
                gap_r <= 2'h3;
            end else if (acceptEn && coreReq.valid) begin
                seen_r <= seen_r + 4'h1; // slow core sits on it
            end
        end
    end
endmodule : core_model

// ---- dv/priority_arbiter_tb_top.sv ----
// self-checking bench for the interrupt priority arbiter
module priority_arbiter_tb_top
    import prio_arbiter_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, rst_n, we_i, cyc_i, stb_i, ack_o, nmiPin, acceptEn;
    logic [9:0] adr_i;
    logic [31:0] dat_i, dat_o, rd;
    logic [3:0] sel_i, waitCycles, lastMask;
    logic [7:0] extPin_n;
    periph_req_type periphReq;
    core_req_type coreReq;
    core_accept_type coreAccept;
    core_mask_type coreMask;
    int nErrors, compares;
    // on-chip sources in rank order: vector and the level programmed below
    localparam logic [19:0][7:0] VEC = {8'h99, 8'h98, 8'h94, 8'h90, 8'h8A, 8'h87, 8'h86,
        8'h85, 8'h84, 8'h6C, 8'h69, 8'h68, 8'h64, 8'h61, 8'h60, 8'h5C, 8'h5B, 8'h5A, 8'h59, 8'h58};
    localparam logic [19:0][3:0] LVL = 80'hCCBA9888876654432222;
    priority_arbiter uut (.clock(clock), .rst_n(rst_n), .adr_i(adr_i), .dat_i(dat_i),
        .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
        .nmiPin(nmiPin), .extPin_n(extPin_n), .periphReq(periphReq), .coreReq(coreReq),
        .coreAccept(coreAccept), .coreMask(coreMask));
    core_model core (.clock(clock), .rst_n(rst_n), .coreReq(coreReq), .acceptEn(acceptEn),
        .waitCycles(waitCycles), .coreAccept(coreAccept));
    // ******************************
    // helpers
    // ******************************
    always #10 clock = ~clock;
    // keep the last mask level the core was told to load
    always @(posedge clock) if (coreMask.load === 1'b1) lastMask <= coreMask.level;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            nErrors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one classic cycle; read data taken at the ack edge only
    task automatic wbCycle(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
        int n = 0;
        @(posedge clock);
        {cyc_i, stb_i, we_i, sel_i} <= {2'b11, wr, 4'h3};
        adr_i <= {idx, 2'b00};
        dat_i <= {16'h0000, wd};
        do begin
            @(posedge clock);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) nErrors++; // a hung slave counts as a fault
        rd = dat_o;
        {cyc_i, stb_i, we_i} <= 3'b000;
    endtask : wbCycle
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick
    task automatic completeRun();
        $display("checks %0d mismatches %0d", compares, nErrors);
        if (nErrors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : completeRun
    // sized well past the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clock);
        nErrors++;
        completeRun();
    end
    // ******************************
    // tests
    // ******************************
    initial begin
        {clock, rst_n, cyc_i, stb_i, we_i, acceptEn} = '0;
        {adr_i, dat_i, sel_i, waitCycles} = '0;
        {nmiPin, extPin_n, periphReq} = {1'b1, 8'hFF, 20'h0};
        {nErrors, compares} = '0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            wbCycle(0, IDX_PRIO_FIRST + 8'(2 * i), 0);
            check("prio reset", rd, 0);
            wbCycle(1, IDX_PRIO_FIRST + 8'(2 * i), 16'hFFFF);
            wbCycle(0, IDX_PRIO_FIRST + 8'(2 * i), 0);
            check("prio bits", rd, {16'h0000, PRIO_WMASK[i]});
        end
        wbCycle(0, IDX_DETECT_CTRL, 0);
        check("control reset", rd, 32'h8000);
        wbCycle(0, 8'h10, 0);
        check("unmapped", rd, 0);
        // two level pins at one level, then pin 1 raised
        wbCycle(1, IDX_PRIO_FIRST, 16'h5500);
        extPin_n <= 8'hFC;
        tick(3);
        check("tie", coreReq, {1'b1, 5'h05, 8'h40, 10'h100});
        wbCycle(0, IDX_EXT_STATUS, 0);
        check("level flags", rd, 32'hC0);
        wbCycle(1, IDX_PRIO_FIRST, 16'h5600);
        tick(3);
        check("higher pin", coreReq.vector, 8'h41);
        waitCycles <= 4'h3; // slow core
        acceptEn <= 1'b1;
        tick(8);
        acceptEn <= 1'b0;
        tick(3);
        check("pin mask", lastMask, 4'h6);
        extPin_n <= 8'hFE;
        tick(3);
        check("pin withdrawn", coreReq.vector, 8'h40);
        wbCycle(1, IDX_PRIO_FIRST, 16'h0600);
        tick(3);
        check("masked", coreReq.valid, 0);
        // falling-edge pin 2: held, blind write ignored, read-then-write cancels
        extPin_n <= 8'hFF;
        waitCycles <= 4'h0;
        wbCycle(1, IDX_DETECT_CTRL, 16'h0020);
        wbCycle(1, IDX_PRIO_FIRST, 16'h0030);
        extPin_n <= 8'hFB; // pin index 2 low, status bit 5
        tick(2);
        extPin_n <= 8'hFF;
        tick(3);
        check("edge held", coreReq, {1'b1, 5'h03, 8'h42, 10'h108});
        wbCycle(1, IDX_EXT_STATUS, 0);
        tick(2);
        check("blind clear", coreReq.valid, 1);
        wbCycle(0, IDX_EXT_STATUS, 0);
        check("edge flag", rd, 32'h20);
        wbCycle(1, IDX_EXT_STATUS, 0);
        tick(2);
        check("cancel", coreReq.valid, 0);
        extPin_n <= 8'hFB;
        tick(3);
        acceptEn <= 1'b1;
        tick(4);
        acceptEn <= 1'b0;
        tick(2);
        check("auto clear", coreReq.valid, 0);
        check("edge mask", lastMask, 4'h3);
        // nonmaskable, falling then rising edge
        extPin_n <= 8'hFF;
        nmiPin <= 1'b0;
        tick(3);
        check("nmi", coreReq, {1'b1, 5'h10, 8'h0B, 10'h02C});
        acceptEn <= 1'b1;
        tick(4);
        acceptEn <= 1'b0;
        tick(2);
        check("nmi mask", lastMask, 4'hF);
        check("nmi taken", coreReq.valid, 0);
        wbCycle(1, IDX_DETECT_CTRL, 16'h0100);
        nmiPin <= 1'b1;
        tick(3);
        check("rising nmi", coreReq.vector, 8'h0B);
        acceptEn <= 1'b1;
        tick(4);
        acceptEn <= 1'b0;
        // every on-chip source alone, then all together
        wbCycle(1, IDX_PRIO_FOURTH, 16'h2345);
        wbCycle(1, IDX_PRIO_FIFTH, 16'h6700);
        wbCycle(1, IDX_PRIO_SIXTH, 16'h0008);
        wbCycle(1, IDX_PRIO_SEVENTH, 16'h90AB);
        wbCycle(1, IDX_PRIO_EIGHTH, 16'hC000);
        for (int i = 0; i < 20; i++) begin
            periphReq <= periph_req_type'(20'h1 << i);
            tick(3);
            check("periph vector", coreReq.vector, VEC[i]);
            check("periph level", coreReq.level, 5'(LVL[i]));
        end
        periphReq <= '1;
        tick(3);
        check("rank", coreReq.vector, 8'h98);
        periphReq <= periph_req_type'(20'h0000F);
        tick(3);
        check("shared field", coreReq.vector, 8'h58);
        completeRun();
    end
endmodule : priority_arbiter_tb_top
